// ==== hw/pafs_defines.svh ====
// offsets, field positions, reset values for the port a pin function select block
`ifndef PAFS_DEFINES_SVH
`define PAFS_DEFINES_SVH

// ==========================================
// register offsets (low address byte)
`define PAFS_ADDR_W 8
`define PAFS_OFS_DIR 8'hc4
`define PAFS_OFS_FUNC_UP 8'hc8
`define PAFS_OFS_FUNC_LO 8'hca

// ==========================================
// power-on reset values
`define PAFS_DIR_RST 16'h0000
`define PAFS_FUNC_UP_RST 16'h3302
`define PAFS_FUNC_LO_RST 16'hff95
`define PAFS_PERIPH_IN_IDLE 13'h1f81

// ==========================================
// fields of the upper select register
`define PAFS_P15_MSB 15
`define PAFS_P14_MSB 13
`define PAFS_P13_MSB 11
`define PAFS_P12_MSB 9
`define PAFS_P11_MSB 7
`define PAFS_P10_MSB 5
`define PAFS_P9_MSB 3
`define PAFS_UP_RSVD_BIT 1
`define PAFS_P8_BIT 0

// ==========================================
// reserved bits that always read one
`define PAFS_FUNC_UP_ONES 16'h0002
`define PAFS_FUNC_LO_ONES 16'haa00

`endif

// ==== hw/pafs_pkg.sv ====
// types shared by the port a pin function select block
package pafs_pkg;

  // ==========================================
  // two-bit pin function code
  typedef enum logic [1:0] {
    PAFS_GPIO = 2'h0,
    PAFS_FN1 = 2'h1,
    PAFS_FN2 = 2'h2,
    PAFS_FN3 = 2'h3
  } pafs_code_t;

  // ==========================================
  // peripheral drive toward the upper pins
  typedef struct packed {
    logic dma_acknowledge_1;
    logic dma_acknowledge_0;
    logic timer_capcomp_b1;
    logic timer_capcomp_a1;
    logic upper_parity_io;
    logic upper_parity_oe;
    logic lower_parity_io;
    logic lower_parity_oe;
    logic address_hold_out_n;
    logic interrupt_request_out;
  } pafs_periph_out_t;

  // ==========================================
  // pin levels routed back to peripherals
  typedef struct packed {
    logic [3:0] ext_int_req;
    logic dma_request_1;
    logic dma_request_0;
    logic timer_ext_clock_a;
    logic timer_ext_clock_b;
    logic timer_capcomp_b1;
    logic timer_capcomp_a1;
    logic upper_parity_io;
    logic lower_parity_io;
    logic bus_request_in;
  } pafs_periph_in_t;

endpackage : pafs_pkg

// ==== hw/pafs_top.sv ====
// port a direction and upper-half pin function select with pad multiplexer
//
// How it works
// - direction bit one drives, zero listens
// - direction matters only for gpio and capture/compare
// - direction clears on power-on reset only
// - select registers load patterns on power-on only
// - upper register pins 15-8, lower pins 7-0
// - pin15: gpio, ext_int_req_3, reserved, dma request 1
// - pin14: gpio, ext_int_req_2, reserved, dma ack 1
// - pin13: gpio, ext_int_req_1, timer clock b, dma_request_0
// - pin12: gpio, ext_int_req_0, timer clock a, dma_acknowledge_0
// - pin11: gpio, upper parity, capcomp b1, reserved
// - pin10: gpio, lower parity, capcomp a1, reserved
// - pin9: gpio, address hold, reserved, irq out
// - upper bit 1 reads one always
// - pin8: gpio or bus request input
// - every pin selectable alone, mode independent
`timescale 1ns/1ps
`include "pafs_defines.svh"

module pafs_top (
  // clock and power-on reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // register port
  input wire logic [`PAFS_ADDR_W-1:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  // upper pads, pins 15 to 8
  input wire logic [15:8] I_PAD_IN,
  output logic [15:8] O_PAD_OUT,
  output logic [15:8] O_PAD_OE_N,
  // general io data
  input wire logic [15:8] I_GPIO_OUT,
  output logic [15:8] O_GPIO_IN,
  // peripherals
  input wire pafs_pkg::pafs_periph_out_t I_PERIPH,
  output pafs_pkg::pafs_periph_in_t O_PERIPH,
  // lower half, muxed elsewhere
  output logic [15:0] O_DIR,
  output logic [15:0] O_FUNC_LOWER
);

  // ==========================================
  // registers
  logic [15:0] dir_q;
  logic [15:0] func_up_q;
  logic [15:0] func_lo_q;
  logic [15:0] rdata_q;
  logic wr_dir;
  logic wr_up;
  logic wr_lo;

  assign wr_dir = I_WR && (I_ADDR == `PAFS_OFS_DIR);
  assign wr_up = I_WR && (I_ADDR == `PAFS_OFS_FUNC_UP);
  assign wr_lo = I_WR && (I_ADDR == `PAFS_OFS_FUNC_LO);

  // the only reset here is power-on; manual reset, standby and sleep never reach these flops
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      dir_q <= `PAFS_DIR_RST;
    end else if (wr_dir) begin
      dir_q <= I_WDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      func_up_q <= `PAFS_FUNC_UP_RST;
    end else if (wr_up) begin
      func_up_q <= I_WDATA | `PAFS_FUNC_UP_ONES;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      func_lo_q <= `PAFS_FUNC_LO_RST;
    end else if (wr_lo) begin
      func_lo_q <= I_WDATA | `PAFS_FUNC_LO_ONES;
    end
  end

  // read data stands for exactly the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !I_RD) begin
      rdata_q <= 16'h0000;
    end else begin
      unique case (I_ADDR)
        `PAFS_OFS_DIR: rdata_q <= dir_q;
        `PAFS_OFS_FUNC_UP: rdata_q <= func_up_q | `PAFS_FUNC_UP_ONES;
        `PAFS_OFS_FUNC_LO: rdata_q <= func_lo_q | `PAFS_FUNC_LO_ONES;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign O_RDATA = rdata_q;

  // ==========================================
  // pad multiplexer
  pafs_pkg::pafs_code_t c15;
  pafs_pkg::pafs_code_t c14;
  pafs_pkg::pafs_code_t c13;
  pafs_pkg::pafs_code_t c12;
  pafs_pkg::pafs_code_t c11;
  pafs_pkg::pafs_code_t c10;
  pafs_pkg::pafs_code_t c9;
  logic [15:8] out_d;
  logic [15:8] oe_n_d;
  logic [15:8] gpio_d;
  logic [15:8] out_q;
  logic [15:8] oe_n_q;
  logic [15:8] gpio_q;
  pafs_pkg::pafs_periph_in_t pin_d;
  pafs_pkg::pafs_periph_in_t pin_q;

  // each pin decodes only its own field, whatever the chip mode
  assign c15 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P15_MSB -: 2]);
  assign c14 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P14_MSB -: 2]);
  assign c13 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P13_MSB -: 2]);
  assign c12 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P12_MSB -: 2]);
  assign c11 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P11_MSB -: 2]);
  assign c10 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P10_MSB -: 2]);
  assign c9 = pafs_pkg::pafs_code_t'(func_up_q[`PAFS_P9_MSB -: 2]);

  always_comb begin
    // general io is the fallback, so reserved codes land here too
    out_d = I_GPIO_OUT;
    oe_n_d = ~dir_q[15:8];
    gpio_d = I_PAD_IN;
    // request lines idle high so a deselected pin never asserts one
    pin_d = '0;
    pin_d.ext_int_req = 4'hf;
    pin_d.dma_request_1 = 1'b1;
    pin_d.dma_request_0 = 1'b1;
    pin_d.bus_request_in = 1'b1;
    unique case (c15)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[15] = 1'b1;
        gpio_d[15] = 1'b0;
        pin_d.ext_int_req[3] = I_PAD_IN[15];
      end
      pafs_pkg::PAFS_FN3: begin
        oe_n_d[15] = 1'b1;
        gpio_d[15] = 1'b0;
        pin_d.dma_request_1 = I_PAD_IN[15];
      end
      pafs_pkg::PAFS_GPIO, pafs_pkg::PAFS_FN2: begin
      end
    endcase
    unique case (c14)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[14] = 1'b1;
        gpio_d[14] = 1'b0;
        pin_d.ext_int_req[2] = I_PAD_IN[14];
      end
      pafs_pkg::PAFS_FN3: begin
        oe_n_d[14] = 1'b0;
        gpio_d[14] = 1'b0;
        out_d[14] = I_PERIPH.dma_acknowledge_1;
      end
      pafs_pkg::PAFS_GPIO, pafs_pkg::PAFS_FN2: begin
      end
    endcase
    unique case (c13)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[13] = 1'b1;
        gpio_d[13] = 1'b0;
        pin_d.ext_int_req[1] = I_PAD_IN[13];
      end
      pafs_pkg::PAFS_FN2: begin
        oe_n_d[13] = 1'b1;
        gpio_d[13] = 1'b0;
        pin_d.timer_ext_clock_b = I_PAD_IN[13];
      end
      pafs_pkg::PAFS_FN3: begin
        oe_n_d[13] = 1'b1;
        gpio_d[13] = 1'b0;
        pin_d.dma_request_0 = I_PAD_IN[13];
      end
      pafs_pkg::PAFS_GPIO: begin
      end
    endcase
    unique case (c12)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[12] = 1'b1;
        gpio_d[12] = 1'b0;
        pin_d.ext_int_req[0] = I_PAD_IN[12];
      end
      pafs_pkg::PAFS_FN2: begin
        oe_n_d[12] = 1'b1;
        gpio_d[12] = 1'b0;
        pin_d.timer_ext_clock_a = I_PAD_IN[12];
      end
      pafs_pkg::PAFS_FN3: begin
        oe_n_d[12] = 1'b0;
        gpio_d[12] = 1'b0;
        out_d[12] = I_PERIPH.dma_acknowledge_0;
      end
      pafs_pkg::PAFS_GPIO: begin
      end
    endcase
    unique case (c11)
      pafs_pkg::PAFS_FN1: begin
        // parity direction follows the data bus, not the direction bit
        oe_n_d[11] = ~I_PERIPH.upper_parity_oe;
        gpio_d[11] = 1'b0;
        out_d[11] = I_PERIPH.upper_parity_io;
        pin_d.upper_parity_io = I_PAD_IN[11];
      end
      pafs_pkg::PAFS_FN2: begin
        gpio_d[11] = 1'b0;
        out_d[11] = I_PERIPH.timer_capcomp_b1;
        pin_d.timer_capcomp_b1 = I_PAD_IN[11];
      end
      pafs_pkg::PAFS_GPIO, pafs_pkg::PAFS_FN3: begin
      end
    endcase
    unique case (c10)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[10] = ~I_PERIPH.lower_parity_oe;
        gpio_d[10] = 1'b0;
        out_d[10] = I_PERIPH.lower_parity_io;
        pin_d.lower_parity_io = I_PAD_IN[10];
      end
      pafs_pkg::PAFS_FN2: begin
        gpio_d[10] = 1'b0;
        out_d[10] = I_PERIPH.timer_capcomp_a1;
        pin_d.timer_capcomp_a1 = I_PAD_IN[10];
      end
      pafs_pkg::PAFS_GPIO, pafs_pkg::PAFS_FN3: begin
      end
    endcase
    unique case (c9)
      pafs_pkg::PAFS_FN1: begin
        oe_n_d[9] = 1'b0;
        gpio_d[9] = 1'b0;
        out_d[9] = I_PERIPH.address_hold_out_n;
      end
      pafs_pkg::PAFS_FN3: begin
        oe_n_d[9] = 1'b0;
        gpio_d[9] = 1'b0;
        out_d[9] = I_PERIPH.interrupt_request_out;
      end
      pafs_pkg::PAFS_GPIO, pafs_pkg::PAFS_FN2: begin
      end
    endcase
    if (func_up_q[`PAFS_P8_BIT]) begin
      oe_n_d[8] = 1'b1;
      gpio_d[8] = 1'b0;
      pin_d.bus_request_in = I_PAD_IN[8];
    end
  end

  // registered pad side costs one cycle of latency but keeps every output glitch free
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      out_q <= 8'h00;
    end else begin
      out_q <= out_d;
    end
  end

  // pads come up as inputs so nothing fights a board driver during reset
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      oe_n_q <= 8'hff;
    end else begin
      oe_n_q <= oe_n_d;
    end
  end

  // a pin lent to a peripheral reads zero on the port side
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      gpio_q <= 8'h00;
    end else begin
      gpio_q <= gpio_d;
    end
  end

  // requests leave reset at their idle level, so no false request reaches dma or interrupt logic
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pin_q <= `PAFS_PERIPH_IN_IDLE;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign O_PAD_OUT = out_q;
  assign O_PAD_OE_N = oe_n_q;
  assign O_GPIO_IN = gpio_q;
  assign O_PERIPH = pin_q;
  assign O_DIR = dir_q;
  assign O_FUNC_LOWER = func_lo_q;

endmodule : pafs_top

// ==== dv/pafs_props.sv ====
// concurrent checks on the port a pin function select block
`timescale 1ns/1ps
module pafs_props (
  // clock, reset, register port
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [15:0] O_RDATA,
  // pads and peripherals
  input wire logic [15:8] I_PAD_IN,
  input wire logic [15:8] O_PAD_OUT,
  input wire logic [15:8] O_PAD_OE_N,
  input wire pafs_pkg::pafs_periph_out_t I_PERIPH,
  input wire pafs_pkg::pafs_periph_in_t O_PERIPH,
  input wire logic [15:0] O_DIR,
  input wire logic [15:0] O_FUNC_LOWER
);
  // ========
  // upper register mirror, it has no port of its own
  logic [15:0] up_q;
  logic rst_q;
  always_ff @(posedge I_CORE_CLK) begin
    rst_q <= I_RST;
    if (I_RST) up_q <= 16'h3302;
    else if (I_WR && I_ADDR == 8'hc8) up_q <= I_WDATA | 16'h0002;
  end
  default clocking dcb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // ========
  // register port
  a_dir_write: assert property (I_WR && I_ADDR == 8'hc4 |=> O_DIR == $past(I_WDATA))
    else $error("direction write lost");
  a_dir_keep: assert property (!(I_WR && I_ADDR == 8'hc4) |=> $stable(O_DIR))
    else $error("direction changed without write");
  a_por_values: assert property ($past(I_RST) |-> O_DIR == 16'h0 && O_FUNC_LOWER == 16'hff95)
    else $error("bad power-on value");
  a_rd_dir: assert property (I_RD && I_ADDR == 8'hc4 |=> O_RDATA == $past(O_DIR))
    else $error("direction read wrong");
  a_rd_lower: assert property (I_RD && I_ADDR == 8'hca |=> O_RDATA == $past(O_FUNC_LOWER))
    else $error("lower read wrong");
  a_rd_upper: assert property (I_RD && I_ADDR == 8'hc8 |=> O_RDATA == $past(up_q))
    else $error("upper read wrong");
  a_rd_quiet: assert property (!(I_RD && I_ADDR inside {8'hc4, 8'hc8, 8'hca}) |=> O_RDATA == 16'h0)
    else $error("read data not zero");
  // ========
  // pad multiplexer, one cycle behind its sources
  a_pin8_gpio: assert property (!rst_q && !$past(up_q[0]) |-> O_PAD_OE_N[8] == !$past(O_DIR[8]))
    else $error("pin 8 direction wrong");
  a_pin8_bus_request_in: assert property (!rst_q && $past(up_q[0]) |-> O_PAD_OE_N[8] &&
    O_PERIPH.bus_request_in == $past(I_PAD_IN[8])) else $error("pin 8 bus request wrong");
  a_pin14_dack: assert property (!rst_q && $past(up_q[13:12]) == 2'h3 |-> !O_PAD_OE_N[14] &&
    O_PAD_OUT[14] == $past(I_PERIPH.dma_acknowledge_1)) else $error("pin 14 ack wrong");
  a_pin15_irq: assert property (!rst_q && $past(up_q[15:14]) == 2'h1 |-> O_PAD_OE_N[15] &&
    O_PERIPH.ext_int_req[3] == $past(I_PAD_IN[15])) else $error("pin 15 irq wrong");
  c_dack: cover property (!O_PAD_OE_N[14] && O_PAD_OUT[14]);
  c_bus_request_in: cover property (up_q[0] && I_PAD_IN[8]);
  c_rd_up: cover property (I_RD && I_ADDR == 8'hc8);
endmodule : pafs_props

bind pafs_top pafs_props u_props (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PAD_IN(I_PAD_IN),
  .O_PAD_OUT(O_PAD_OUT), .O_PAD_OE_N(O_PAD_OE_N), .I_PERIPH(I_PERIPH), .O_PERIPH(O_PERIPH),
  .O_DIR(O_DIR), .O_FUNC_LOWER(O_FUNC_LOWER));

// ==== dv/pafs_top_tb.sv ====
// self-checking bench for the port a pin function select block
`timescale 1ns/1ps
module pafs_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, dir, flo;
  logic [15:8] pin = 8'h00;
  logic [15:8] gout = 8'h00;
  logic [15:8] pout, oen, gin;
  pafs_pkg::pafs_periph_out_t per = '0;
  pafs_pkg::pafs_periph_in_t pst;
  int fail_count = 0;
  int compares = 0;

  pafs_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE_N(oen),
    .I_GPIO_OUT(gout), .O_GPIO_IN(gin), .I_PERIPH(per), .O_PERIPH(pst), .O_DIR(dir),
    .O_FUNC_LOWER(flo));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ========
  // access and compare tasks; each strobe is one cycle long and followed by one idle cycle
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask : rd_chk

  // pad out is only compared on pins that are driven
  task automatic pchk(input logic [7:0] o, input logic [7:0] d, input logic [7:0] gi, input logic [12:0] p);
    @(posedge clk);
    @(negedge clk);
    chk({8'h00, oen}, {8'h00, o});
    chk({8'h00, pout & ~o}, {8'h00, d});
    chk({8'h00, gin}, {8'h00, gi});
    chk({3'h0, pst}, {3'h0, p});
    @(posedge clk);
  endtask : pchk

  task automatic end_sim;
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ========
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'hc4, 16'h0000);
    rd_chk(8'hc8, 16'h3302);
    rd_chk(8'hca, 16'hff95);
    rd_chk(8'hc6, 16'h0000);
    pchk(8'haf, 8'h00, 8'h00, 13'h1f81);
    wr_reg(8'hc6, 16'hffff);
    rd_chk(8'hc4, 16'h0000);
    wr_reg(8'hc8, 16'ha0f8);
    rd_chk(8'hc8, 16'ha0fa);
    wr_reg(8'hca, 16'h0000);
    rd_chk(8'hca, 16'haa00);
    wr_reg(8'hc4, 16'hffff);
    rd_chk(8'hc4, 16'hffff);
    gout <= 8'ha5;
    pchk(8'h00, 8'ha5, 8'h00, 13'h1f81);
    wr_reg(8'hc4, 16'h0000);
    pin <= 8'hc5;
    pchk(8'hff, 8'h00, 8'hc5, 13'h1f81);
    wr_reg(8'hc4, 16'hffff);
    wr_reg(8'hc8, 16'h7e6f);
    per <= 10'h271;
    pin <= 8'h00;
    pchk(8'hb1, 8'h4e, 8'h00, 13'h0f00);
    wr_reg(8'hc8, 16'hd996);
    per <= 10'h088;
    pin <= 8'hc5;
    pchk(8'hf4, 8'h09, 8'h01, 13'h1d83);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'hc4, 16'h0000);
    rd_chk(8'hc8, 16'h3302);
    pchk(8'haf, 8'h00, 8'h85, 13'h1f81);
    end_sim();
  end
endmodule : pafs_top_tb
